// File: dpu_top.sv
// Function
// - Keep the ten newest alarms with code and time stamp.
// - Stamp counts supply on-time in 100 ms ticks, captured at alarm.
// - Operating-time counter spans about 13 years without wrapping.
// - Long shift press enters alarm history showing the newest entry.
// - Down key steps to older entry, up key to newer.
// - Short shift presses cycle code, low four, middle four, upper two digits.
// - Same alarm code within one hour is not recorded again.
// - History survives alarm reset; only history clear or rst_i erases it.
// - Jog starts only when all start interlocks are satisfied.
// - Travel-limit protection is ignored while jog runs.
// - Jog speed accepts 0 to 10000, default 500.
// - Direct-drive motor makes the jog speed unit 0.1 rpm.
// - Motor turns at jog speed only while up or down key held.
// - Mode key toggles motor power; long shift press removes it.
// - Origin search turns to index pulse and clamps there.
// - Origin search runs at 60 rpm, 6 rpm for direct drive.
// - Travel-inhibit inputs have no effect during origin search.
// - Origin search starts only when all start interlocks are satisfied.
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module dpu_top #(
  parameter int TICK_CYC = dpu_pkg::TICK_CYC,
  parameter int HOLD_CYC = dpu_pkg::HOLD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire dpu_pkg::dpu_keys_s keys_i,
  input wire dpu_pkg::dpu_ilk_s ilk_i,
  input wire logic ctrl_pwr_i,
  input wire logic dd_motor_i,
  input wire logic [7:0] alarm_code_i,
  input wire logic index_i,
  input wire logic fwd_inhibit_i,
  input wire logic rev_inhibit_i,
  output logic motor_en_o,
  output logic signed [17:0] speed_o,
  output logic clamp_o,
  output logic ot_stop_o,
  output dpu_pkg::dpu_disp_s disp_o,
  output logic irq_o
);
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);
  localparam logic [31:0] HOLD_LAST = 32'(HOLD_CYC - 1);
  localparam logic [31:0] HOUR_T = 32'(dpu_pkg::HOUR_TICKS);
  localparam logic [3:0] HIST_MAX = 4'(dpu_pkg::HIST_N);

  dpu_pkg::dpu_state_e st_q;
  dpu_pkg::dpu_entry_s hist_q [dpu_pkg::HIST_N];
  dpu_pkg::dpu_keys_s key_q;
  logic [3:0] cnt_q;
  logic [3:0] idx_q;
  logic [1:0] phase_q;
  logic [31:0] tick_q;
  logic [31:0] optime_q;
  logic [31:0] hold_q;
  logic lfired_q;
  logic alm_q;
  logic srv_q;
  logic done_q;
  logic [1:0] fsel_q;
  logic wperm_q;
  logic rotinv_q;
  logic [15:0] jog_q;
  logic [2:0] irq_st_q;
  logic [2:0] irq_en_q;

  // Bus decode
  logic wb_req;
  logic wb_wr;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes take effect at the edge where the master sees ack high
  assign wb_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

  // Key events
  logic long_ev;
  logic short_ev;
  logic up_ev;
  logic dn_ev;
  logic mode_ev;
  assign long_ev = keys_i.shift & ~lfired_q & (hold_q == HOLD_LAST);
  assign short_ev = key_q.shift & ~keys_i.shift & ~lfired_q;
  assign up_ev = keys_i.up & ~key_q.up;
  assign dn_ev = keys_i.down & ~key_q.down;
  assign mode_ev = keys_i.mode & ~key_q.mode;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_q <= '0;
      hold_q <= '0;
      lfired_q <= 1'b0;
    end else begin
      key_q <= keys_i;
      if (!keys_i.shift) begin
        hold_q <= '0;
        lfired_q <= 1'b0;
      end else if (long_ev) begin
        lfired_q <= 1'b1;
      end else if (!lfired_q) begin
        hold_q <= hold_q + 32'h0000_0001;
      end
    end
  end

  // Operating time in 100 ms ticks, 32 bits last about 13.6 years
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_q <= '0;
      optime_q <= '0;
    end else if (tick_q == TICK_LAST) begin
      tick_q <= '0;
      if (ctrl_pwr_i) begin
        optime_q <= optime_q + 32'h0000_0001;
      end
    end else begin
      tick_q <= tick_q + 32'h0000_0001;
    end
  end

  // Alarm capture and repeat filter
  logic alm_ev;
  logic rep_hit;
  logic [31:0] rep_stamp;
  logic store;
  logic hclr;
  assign alm_ev = ilk_i.alarm & ~alm_q;
  assign hclr = wb_wr & (wb_adr_i == dpu_pkg::A_HCLR) & wb_dat_i[0];

  always_comb begin
    rep_hit = 1'b0;
    rep_stamp = '0;
    for (int i = dpu_pkg::HIST_N - 1; i >= 0; i--) begin
      if (4'(i) < cnt_q && hist_q[i].code == alarm_code_i) begin
        rep_hit = 1'b1;
        rep_stamp = hist_q[i].stamp;
      end
    end
  end

  assign store = alm_ev & ~(rep_hit & (optime_q - rep_stamp <= HOUR_T));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alm_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      alm_q <= ilk_i.alarm;
      if (hclr) begin
        cnt_q <= '0;
      end else if (store && cnt_q != HIST_MAX) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // Newest at entry 0, oldest falls off the end
  always_ff @(posedge clk_i) begin
    if (store) begin
      hist_q[0] <= '{code: alarm_code_i, stamp: optime_q};
    end
  end

  for (genvar g = 1; g < dpu_pkg::HIST_N; g++) begin : g_shift
    always_ff @(posedge clk_i) begin
      if (store) begin
        hist_q[g] <= hist_q[g-1];
      end
    end
  end

  // Function sequencing
  logic start_ok;
  logic moving;
  assign start_ok = wperm_q & ilk_i.main_pwr & ~ilk_i.alarm & ~ilk_i.hardwired_base_block
                    & ~ilk_i.servo_on;
  assign moving = srv_q & (keys_i.up ^ keys_i.down)
                  & ~(st_q == dpu_pkg::ST_ORG && done_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= dpu_pkg::ST_IDLE;
      srv_q <= 1'b0;
      done_q <= 1'b0;
      idx_q <= '0;
      phase_q <= dpu_pkg::P_CODE;
    end else begin
      unique case (st_q)
        dpu_pkg::ST_IDLE: begin
          if (long_ev) begin
            srv_q <= 1'b0;
            done_q <= 1'b0;
            idx_q <= '0;
            phase_q <= dpu_pkg::P_CODE;
            if (fsel_q == dpu_pkg::F_HIST) begin
              st_q <= dpu_pkg::ST_HIST;
            end else if (fsel_q == dpu_pkg::F_JOG && start_ok) begin
              st_q <= dpu_pkg::ST_JOG;
            end else if (fsel_q == dpu_pkg::F_ORG && start_ok) begin
              st_q <= dpu_pkg::ST_ORG;
            end
          end
        end
        dpu_pkg::ST_HIST: begin
          if (long_ev) begin
            st_q <= dpu_pkg::ST_IDLE;
          end else if (short_ev) begin
            phase_q <= phase_q + 2'h1;
          end else if (dn_ev && idx_q + 4'h1 < cnt_q) begin
            idx_q <= idx_q + 4'h1;
            phase_q <= dpu_pkg::P_CODE;
          end else if (up_ev && idx_q != 4'h0) begin
            idx_q <= idx_q - 4'h1;
            phase_q <= dpu_pkg::P_CODE;
          end
        end
        dpu_pkg::ST_JOG, dpu_pkg::ST_ORG: begin
          if (ilk_i.alarm) begin
            srv_q <= 1'b0;
          end else if (long_ev) begin
            srv_q <= 1'b0;
            if (!srv_q) begin
              st_q <= dpu_pkg::ST_IDLE;
            end
          end else if (mode_ev) begin
            srv_q <= ~srv_q;
            done_q <= 1'b0;
          end else if (st_q == dpu_pkg::ST_ORG && moving && index_i) begin
            done_q <= 1'b1;
          end
        end
      endcase
    end
  end

  // Motor outputs
  logic [17:0] mag;
  logic rev;
  always_comb begin
    rev = keys_i.down ^ rotinv_q;
    if (st_q == dpu_pkg::ST_ORG) begin
      mag = dd_motor_i ? dpu_pkg::ORG_SPD_DD : dpu_pkg::ORG_SPD;
    end else if (dd_motor_i) begin
      mag = {2'h0, jog_q};
    end else begin
      mag = 18'({2'h0, jog_q} * dpu_pkg::SCALE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      motor_en_o <= 1'b0;
      speed_o <= '0;
      clamp_o <= 1'b0;
      ot_stop_o <= 1'b0;
    end else begin
      motor_en_o <= srv_q;
      clamp_o <= done_q & srv_q;
      if (moving) begin
        speed_o <= rev ? -$signed(mag) : $signed(mag);
      end else begin
        speed_o <= '0;
      end
      ot_stop_o <= (fwd_inhibit_i | rev_inhibit_i)
                   & (st_q != dpu_pkg::ST_JOG) & (st_q != dpu_pkg::ST_ORG);
    end
  end

  // History display
  logic [31:0] stamp;
  assign stamp = hist_q[idx_q].stamp;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      disp_o <= '0;
    end else begin
      disp_o.valid <= (st_q == dpu_pkg::ST_HIST) && idx_q < cnt_q;
      disp_o.seq <= idx_q;
      disp_o.phase <= phase_q;
      unique case (phase_q)
        dpu_pkg::P_CODE: disp_o.value <= {8'h00, hist_q[idx_q].code};
        dpu_pkg::P_LOW: disp_o.value <= 16'(stamp % dpu_pkg::DEC4);
        dpu_pkg::P_MID: begin
          disp_o.value <= 16'((stamp / dpu_pkg::DEC4) % dpu_pkg::DEC4);
        end
        dpu_pkg::P_HIGH: disp_o.value <= 16'(stamp / dpu_pkg::DEC8);
      endcase
    end
  end

  // Registers
  logic [15:0] jog_d;
  always_comb begin
    jog_d = jog_q;
    jog_d[7:0] = wb_dat_i[7:0];
    if (wb_sel_i[1]) begin
      jog_d[15:8] = wb_dat_i[15:8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fsel_q <= dpu_pkg::F_HIST;
      wperm_q <= 1'b0;
      rotinv_q <= 1'b0;
      jog_q <= dpu_pkg::JOG_DEF;
      irq_en_q <= '0;
    end else if (wb_wr) begin
      unique case (wb_adr_i)
        dpu_pkg::A_CTRL: begin
          fsel_q <= wb_dat_i[dpu_pkg::C_FSEL+:2];
          wperm_q <= wb_dat_i[dpu_pkg::C_WPERM];
          rotinv_q <= wb_dat_i[dpu_pkg::C_ROTINV];
        end
        dpu_pkg::A_JOG: begin
          if (jog_d <= dpu_pkg::JOG_MAX) begin
            jog_q <= jog_d;
          end
        end
        dpu_pkg::A_IRQ_EN: irq_en_q <= wb_dat_i[dpu_pkg::IRQ_N-1:0];
        default: begin
        end
      endcase
    end
  end

  // Sticky events, set wins over clear
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  assign irq_set[dpu_pkg::I_ALM] = store;
  assign irq_set[dpu_pkg::I_ORG] = st_q == dpu_pkg::ST_ORG && moving
                                   && index_i && !done_q;
  assign irq_set[dpu_pkg::I_REF] = st_q == dpu_pkg::ST_IDLE && long_ev
                                   && fsel_q != dpu_pkg::F_HIST && !start_ok;
  assign irq_clr = (wb_wr && wb_adr_i == dpu_pkg::A_IRQ_CLR)
                   ? wb_dat_i[dpu_pkg::IRQ_N-1:0] : 3'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_q <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
      irq_o <= |(irq_st_q & irq_en_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= '0;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          dpu_pkg::A_CTRL: wb_dat_o <= {28'h0, rotinv_q, wperm_q, fsel_q};
          dpu_pkg::A_JOG: wb_dat_o <= {16'h0, jog_q};
          dpu_pkg::A_STAT: begin
            wb_dat_o <= {16'h0, cnt_q, 2'h0, done_q, srv_q, st_q, 4'h0};
          end
          dpu_pkg::A_IRQ_ST: wb_dat_o <= {29'h0, irq_st_q};
          dpu_pkg::A_IRQ_EN: wb_dat_o <= {29'h0, irq_en_q};
          dpu_pkg::A_OPTIME: wb_dat_o <= optime_q;
          dpu_pkg::A_DISP: wb_dat_o <= {9'h0, disp_o};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_find;
    st_q == dpu_pkg::ST_ORG && moving && index_i && !done_q;
  endsequence
  sequence s_clamped;
    clamp_o ##1 (speed_o == 18'h0 && clamp_o);
  endsequence

  wb_ack_a: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus ack not a single cycle");
  irq_level_a: assert property (|(irq_st_q & irq_en_q) |=> irq_o)
    else $error("Enabled event without interrupt");
  start_lock_a: assert property (
    st_q == dpu_pkg::ST_IDLE && long_ev && !start_ok
    |=> st_q inside {dpu_pkg::ST_IDLE, dpu_pkg::ST_HIST})
    else $error("Motor function entered while locked");
  ot_ignore_a: assert property (
    st_q inside {dpu_pkg::ST_JOG, dpu_pkg::ST_ORG} |=> !ot_stop_o)
    else $error("Travel stop during jog or search");
  hist_push_a: assert property (
    store && !hclr |=> hist_q[0].stamp == $past(optime_q)
    && cnt_q != 4'h0 && cnt_q <= HIST_MAX)
    else $error("Alarm not stored");
  rep_drop_a: assert property (
    alm_ev && rep_hit && optime_q - rep_stamp <= HOUR_T && !hclr
    |=> $stable(cnt_q) && $stable(hist_q[0]))
    else $error("Repeat within hour stored");
  phase_step_a: assert property (
    st_q == dpu_pkg::ST_HIST && short_ev && !long_ev
    |=> phase_q == 2'($past(phase_q) + 2'h1))
    else $error("Stamp digit group not advanced");
  older_step_a: assert property (
    st_q == dpu_pkg::ST_HIST && !long_ev && !short_ev && dn_ev
    && idx_q + 4'h1 < cnt_q |=> idx_q == $past(idx_q) + 4'h1)
    else $error("Down key did not step older");
  origin_clamp_a: assert property (
    s_find ##1 (srv_q && !mode_ev && !long_ev && !ilk_i.alarm)
    |=> s_clamped)
    else $error("Search did not clamp at index");
  jog_range_a: assert property (jog_q <= dpu_pkg::JOG_MAX)
    else $error("Jog speed out of range");
  jog_speed_a: assert property (
    moving |=> speed_o == $past(rev ? -$signed(mag) : $signed(mag)))
    else $error("Speed not the set value");
  enter_new_a: assert property (
    st_q == dpu_pkg::ST_IDLE && long_ev && fsel_q == dpu_pkg::F_HIST
    |=> st_q == dpu_pkg::ST_HIST && idx_q == 4'h0)
    else $error("History not entered at newest");
endmodule // dpu_top

// File: dpu_pkg.sv
package dpu_pkg;
  // Timing
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 100_000_000;
  localparam int HOLD_NS = 1_000_000_000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int HOLD_CYC = HOLD_NS / CLK_NS;
  localparam int TICK_MS = 100;
  localparam int HOUR_MS = 3_600_000;
  localparam int HOUR_TICKS = HOUR_MS / TICK_MS;
  // History
  localparam int HIST_N = 10;
  localparam int CODE_W = 8;
  localparam int STAMP_W = 32;
  localparam int IDX_W = 4;
  localparam logic [31:0] DEC4 = 32'h0000_2710;
  localparam logic [31:0] DEC8 = 32'h05F5_E100;
  // Speeds, output unit is 0.1 rpm
  localparam int SPD_W = 18;
  localparam logic [15:0] JOG_MAX = 16'h2710;
  localparam logic [15:0] JOG_DEF = 16'h01F4;
  localparam logic [17:0] SCALE = 18'h0000A;
  localparam logic [17:0] ORG_SPD = 18'h00258;
  localparam logic [17:0] ORG_SPD_DD = 18'h0003C;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_JOG = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_HCLR = 8'h0C;
  localparam logic [7:0] A_IRQ_ST = 8'h10;
  localparam logic [7:0] A_IRQ_CLR = 8'h14;
  localparam logic [7:0] A_IRQ_EN = 8'h18;
  localparam logic [7:0] A_OPTIME = 8'h1C;
  localparam logic [7:0] A_DISP = 8'h20;
  // CTRL fields
  localparam int C_FSEL = 0;
  localparam int C_WPERM = 2;
  localparam int C_ROTINV = 3;
  // Function select codes
  localparam logic [1:0] F_HIST = 2'h0;
  localparam logic [1:0] F_JOG = 2'h1;
  localparam logic [1:0] F_ORG = 2'h2;
  // Interrupt bits
  localparam int IRQ_N = 3;
  localparam int I_ALM = 0;
  localparam int I_ORG = 1;
  localparam int I_REF = 2;
  // View phases
  localparam logic [1:0] P_CODE = 2'h0;
  localparam logic [1:0] P_LOW = 2'h1;
  localparam logic [1:0] P_MID = 2'h2;
  localparam logic [1:0] P_HIGH = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_HIST = 4'h2,
    ST_JOG = 4'h4,
    ST_ORG = 4'h8
  } dpu_state_e;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic [STAMP_W-1:0] stamp;
  } dpu_entry_s;

  typedef struct packed {
    logic up;
    logic down;
    logic shift;
    logic mode;
  } dpu_keys_s;

  typedef struct packed {
    logic main_pwr;
    logic alarm;
    logic hardwired_base_block;
    logic servo_on;
  } dpu_ilk_s;

  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] seq;
    logic [1:0] phase;
    logic [15:0] value;
  } dpu_disp_s;
endpackage

// File: dpu_operator.sv
`timescale 1ns/1ps
module dpu_operator (
  input wire logic clk_i,
  input wire dpu_pkg::dpu_keys_s want_i,
  output dpu_pkg::dpu_keys_s keys_o
);
  // Fingers follow the wanted keys one cycle late, never faster
  always_ff @(posedge clk_i) begin
    keys_o <= want_i;
  end
endmodule // dpu_operator

// File: tb_dpu_top.sv
`timescale 1ns/1ps
module tb_dpu_top;
  localparam int HOLD = 5;
  localparam int LONG = HOLD + 3;
  localparam logic [3:0] K_UP = 4'h8;
  localparam logic [3:0] K_DN = 4'h4;
  localparam logic [3:0] K_SH = 4'h2;
  localparam logic [3:0] K_MD = 4'h1;
  localparam logic [3:0] BAD [4] = '{4'h8, 4'h0, 4'hA, 4'h9};
  logic clk_i, rst_i, cyc, stb, we, ack, ctrl_pwr, dd, index, fwd, rev;
  logic motor_en, clamp, ot_stop, irq;
  logic [7:0] adr, code;
  logic [31:0] dw, dr, rd, t, sp;
  logic signed [17:0] speed;
  dpu_pkg::dpu_keys_s want, keys;
  dpu_pkg::dpu_ilk_s ilk;
  dpu_pkg::dpu_disp_s disp;
  int errors = 0;
  int samples_checked = 0;
  int cyc_n = 0;

  dpu_operator op (.clk_i(clk_i), .want_i(want), .keys_o(keys));
  dpu_top #(.TICK_CYC(10), .HOLD_CYC(HOLD)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .keys_i(keys), .ilk_i(ilk),
    .ctrl_pwr_i(ctrl_pwr), .dd_motor_i(dd), .alarm_code_i(code),
    .index_i(index), .fwd_inhibit_i(fwd), .rev_inhibit_i(rev),
    .motor_en_o(motor_en), .speed_o(speed), .clamp_o(clamp),
    .ot_stop_o(ot_stop), .disp_o(disp), .irq_o(irq));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      errors++;
      end_of_test();
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Classic cycle: hold everything until ack is sampled, then one idle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task rdr(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask

  task press(input logic [3:0] k, input int n);
    want <= dpu_pkg::dpu_keys_s'(k);
    tick(n);
    want <= '0;
    tick(4);
  endtask

  task dsp(input logic [3:0] s, input logic [1:0] p, input logic [15:0] v);
    chk(32'(disp), 32'({1'b1, s, p, v}));
  endtask

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dw = 32'h0;
    want = '0;
    ilk = dpu_pkg::dpu_ilk_s'(4'h8);
    ctrl_pwr = 1'b1;
    dd = 1'b0;
    code = 8'h00;
    index = 1'b0;
    fwd = 1'b0;
    rev = 1'b0;
    tick(16);
    rst_i <= 1'b0;
    tick(2);
    rdr(dpu_pkg::A_JOG);
    chk(rd, 32'h1F4);
    rdr(dpu_pkg::A_STAT);
    chk(rd, 32'h10);
    rdr(dpu_pkg::A_IRQ_ST);
    chk(rd, 32'h0);
    rdr(8'h24);
    chk(rd, 32'h0);
    $display("test reset done");
    // Write-permission, main-power, base-block and servo-on faults in turn, for jog and for origin search
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, dpu_pkg::A_IRQ_EN, (i == 0) ? 32'h3 : 32'h7);
      wb(1'b1, dpu_pkg::A_CTRL, {29'h0, i % 4 != 0, 2'(1 + i / 4)});
      ilk <= dpu_pkg::dpu_ilk_s'(BAD[i % 4]);
      press(K_SH, LONG);
      rdr(dpu_pkg::A_STAT);
      chk(32'(rd[7:4]), 32'h1);
      rdr(dpu_pkg::A_IRQ_ST);
      chk(32'(rd[2]), 32'h1);
      chk(32'(irq), 32'(i != 0));
      wb(1'b1, dpu_pkg::A_IRQ_CLR, 32'h4);
      tick(2);
      chk(32'(irq), 32'h0);
    end
    $display("test refusal done");
    ilk <= dpu_pkg::dpu_ilk_s'(4'h8);
    wb(1'b1, dpu_pkg::A_JOG, 32'h2711);
    rdr(dpu_pkg::A_JOG);
    chk(rd, 32'h1F4);
    wb(1'b1, dpu_pkg::A_JOG, 32'h2710);
    rdr(dpu_pkg::A_JOG);
    chk(rd, 32'h2710);
    wb(1'b1, dpu_pkg::A_JOG, 32'h64);
    wb(1'b1, dpu_pkg::A_CTRL, 32'h5);
    fwd <= 1'b1;
    press(K_SH, LONG);
    rdr(dpu_pkg::A_STAT);
    chk(32'(rd[7:4]), 32'h4);
    press(K_MD, 2);
    chk(32'(motor_en), 32'h1);
    chk(32'(ot_stop), 32'h0);
    for (int j = 0; j < 4; j++) begin
      dd <= j[1];
      want <= dpu_pkg::dpu_keys_s'(j[0] ? K_DN : K_UP);
      tick(6);
      sp = j[1] ? 32'd100 : 32'd1000;
      chk(32'(speed), j[0] ? -sp : sp);
      want <= '0;
      tick(4);
      chk(32'(speed), 32'h0);
    end
    press(K_MD, 2);
    chk(32'(motor_en), 32'h0);
    press(K_MD, 2);
    chk(32'(motor_en), 32'h1);
    press(K_SH, LONG);
    chk(32'(motor_en), 32'h0);
    rdr(dpu_pkg::A_STAT);
    chk(32'(rd[7:4]), 32'h4);
    press(K_SH, LONG);
    rdr(dpu_pkg::A_STAT);
    chk(32'(rd[7:4]), 32'h1);
    chk(32'(ot_stop), 32'h1);
    $display("test jog done");
    for (int j = 0; j < 2; j++) begin
      dd <= j[0];
      rev <= 1'b1;
      wb(1'b1, dpu_pkg::A_CTRL, j[0] ? 32'hE : 32'h6);
      press(K_SH, LONG);
      press(K_MD, 2);
      want <= dpu_pkg::dpu_keys_s'(K_UP);
      tick(6);
      chk(32'(speed), j[0] ? -32'd60 : 32'd600);
      chk(32'(ot_stop), 32'h0);
      index <= 1'b1;
      tick(1);
      index <= 1'b0;
      tick(3);
      chk(32'(clamp), 32'h1);
      chk(32'(speed), 32'h0);
      want <= '0;
      rdr(dpu_pkg::A_STAT);
      chk(32'(rd[9]), 32'h1);
      rdr(dpu_pkg::A_IRQ_ST);
      chk(32'(rd[1]), 32'h1);
      wb(1'b1, dpu_pkg::A_IRQ_CLR, 32'h7);
      press(K_SH, LONG);
      press(K_SH, LONG);
    end
    $display("test origin done");
    fwd <= 1'b0;
    rev <= 1'b0;
    dd <= 1'b0;
    // Operating time stands still without control supply
    ctrl_pwr <= 1'b0;
    tick(2);
    rdr(dpu_pkg::A_OPTIME);
    t = rd;
    tick(100);
    rdr(dpu_pkg::A_OPTIME);
    chk(rd, t);
    ctrl_pwr <= 1'b1;
    tick(200);
    ctrl_pwr <= 1'b0;
    tick(2);
    rdr(dpu_pkg::A_OPTIME);
    chk(32'((rd - t) inside {[19:21]}), 32'h1);
    t = rd;
    // Eleven alarms, then a repeat of the newest code at once
    for (int k = 0; k < 12; k++) begin
      code <= (k == 11) ? 8'h1A : 8'h10 + 8'(k);
      ilk <= dpu_pkg::dpu_ilk_s'(4'hC);
      tick(3);
      ilk <= dpu_pkg::dpu_ilk_s'(4'h8);
      tick(3);
    end
    rdr(dpu_pkg::A_STAT);
    chk(32'(rd[15:12]), 32'hA);
    rdr(dpu_pkg::A_IRQ_ST);
    chk(32'(rd[0]), 32'h1);
    wb(1'b1, dpu_pkg::A_CTRL, 32'h4);
    press(K_SH, LONG);
    dsp(4'h0, 2'h0, 16'h1A);
    for (int p = 1; p < 5; p++) begin
      press(K_SH, 2);
      dsp(4'h0, 2'(p), p == 1 ? 16'(t % 10000) :
          p == 2 ? 16'((t / 10000) % 10000) :
          p == 3 ? 16'(t / 100000000) : 16'h1A);
    end
    for (int k = 0; k < 10; k++) press(K_DN, 2);
    dsp(4'h9, 2'h0, 16'h11);
    press(K_UP, 2);
    dsp(4'h8, 2'h0, 16'h12);
    press(K_SH, LONG);
    wb(1'b1, dpu_pkg::A_HCLR, 32'h1);
    rdr(dpu_pkg::A_STAT);
    chk(32'(rd[15:12]), 32'h0);
    $display("test history done");
    end_of_test();
  end
endmodule // tb_dpu_top
